//--- design/usspi_top.sv
// Purpose: serial port in master SPI mode with registers and pins
// Assumes: one system clock, register port answers reads next cycle
// Notes:   only the master SPI mode moves data; other modes stay idle
`timescale 1ns/100ps

// How it works
// [R1] mode field 11 selects master SPI; 00, 01, 10 leave the shifter idle
// [R2] order, phase and polarity arrive in the same write as the mode
// [R3] order bit one shifts LSB first, zero shifts MSB first
// [R4] phase bit picks sampling on the leading or trailing clock edge
// [R5] polarity sets clock idle level; with phase fixes setup and sample
// [R6] transmit holds one buffered word while the shifter sends another
// [R7] receive keeps two buffered words beyond the receive shifter
// [R8] no write-collision indication exists in this mode
// [R9] no double-speed control; speed comes only from the baud divisor
// [R10] master only: the block drives the transfer clock while in mode 11 with the transmitter enabled
// [R11] receive-complete flag is high while unread receive data remain
// [R12] disabling the receiver flushes its buffer and clears the flag
// [R13] transmit-complete sets when shifter and buffer are empty
// [R14] buffer-empty flag shows room in transmit buffer, set after reset
// [R15] each interrupt needs its enable, the global flag and its flag
// [R16] enabled receiver takes over the data-in pin
// [R17] receiver alone makes no transfers; transmitter makes the clock
// [R18] transmitter owns data-out pin; disable waits until all is sent
// [R19] software writes zeros to reserved control and status bits
// [R20] data-out, data-in and clock pins; no slave-select input
// [R21] every frame has exactly eight data bits
// [R22] data write starts a transfer; word moves when shifter is ready
// [R23] receive overflow drops the newest word, keeps the older ones
// [R24] frame, overrun and parity error bits always read zero
// [R25] clock line toggles every baud divisor plus one system clocks
module usspi_top
  import usspi_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       clk_en_i,
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_we_i,
  input  wire logic       reg_re_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       global_irq_en_i,
  input  wire logic       txc_irq_ack_i,
  output logic            rxc_irq_o,
  output logic            txc_irq_o,
  output logic            udre_irq_o,
  input  wire logic       serial_in_pin_i,
  output logic            serial_in_own_o,
  output logic            serial_out_pin_o,
  output logic            serial_out_oe_o,
  output logic            transfer_clock_pin_o,
  output logic            transfer_clock_oe_o
);

  logic [7:0]            ctrl_b_q;
  usspi_cfg_t            cfg_q;
  logic [BAUD_W-1:0]     baud_q;
  logic [7:0]            tx_buf_q;
  logic                  tx_full_q;
  logic                  tx_own_q;
  logic                  txc_q;
  usspi_state_t          st_q;
  logic [7:0]            tx_sr_q;
  logic [7:0]            rx_sr_q;
  logic [7:0]            rx_sr_d;
  logic [3:0]            edge_q;
  logic [BAUD_W-1:0]     div_q;
  logic [7:0]            rx_mem_q [2];
  logic [1:0]            rx_cnt_q;
  logic [1:0]            rx_base;
  logic                  din;
  logic                  mspi;
  logic                  wr_data;
  logic                  rd_data;
  logic                  tick;
  logic                  leading;
  logic                  sample_ev;
  logic                  setup_ev;
  logic                  load;
  logic                  frame_done;
  logic                  push;
  logic                  pop;
  logic                  rxc;
  logic                  udre;
  logic                  cur_bit;

  // data-in pin crosses into the system clock here
  usspi_insync u_insync (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .clk_en_i  (clk_en_i),
    .pin_i     (serial_in_pin_i),
    .level_o   (din)
  );

  // [R1] only mode 11 runs the shifter
  assign mspi    = (cfg_q.mode == MODE_MSPI);
  assign wr_data = reg_we_i && (reg_addr_i == REG_DATA);
  assign rd_data = reg_re_i && (reg_addr_i == REG_DATA);

  // [R11] flag follows buffer fill level
  assign rxc  = (rx_cnt_q != 2'h0);
  // [R14] empty whenever the buffer word is free
  assign udre = !tx_full_q;

  // [R25] half period elapses every baud+1 clocks
  assign tick    = (st_q == ST_SHIFT) && (div_q == baud_q);
  assign leading = !edge_q[0];
  // [R4] phase zero samples leading edges, phase one trailing
  assign sample_ev = tick && (leading ^ cfg_q.cpha);
  // [R5] setup on the other edge, none after the last edge
  assign setup_ev  = (tick && !(leading ^ cfg_q.cpha) &&
                      (edge_q != LAST_EDGE)) || (load && !cfg_q.cpha);
  // [R21] sixteen edges make eight bits
  assign frame_done = tick && (edge_q == LAST_EDGE);
  // [R17] only a live transmitter starts frames
  // [R22] buffered word moves over when the shifter is idle
  assign load = mspi && tx_own_q && tx_full_q && (st_q == ST_IDLE);
  // [R3] bit taken from the end that order selects
  assign cur_bit = cfg_q.order ? tx_sr_q[0] : tx_sr_q[FRAME_BITS-1];

  // receive shifter next value, order decides which end fills
  always_comb begin
    rx_sr_d = rx_sr_q;
    if (sample_ev) begin
      // [R3] same order for receive
      if (cfg_q.order) begin
        rx_sr_d = {din, rx_sr_q[7:1]};
      end else begin
        rx_sr_d = {rx_sr_q[6:0], din};
      end
    end
  end

  // [R2] whole control word taken in one write
  // [R9] no double-speed bit: baud divisor alone sets the rate
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_b_q <= CONTROL_B_RST;
      cfg_q    <= '{mode:  CONTROL_C_RST[MODE_HI_BIT:MODE_LO_BIT],
                    order: CONTROL_C_RST[ORDER_BIT],
                    cpha:  CONTROL_C_RST[CPHA_BIT],
                    cpol:  CONTROL_C_RST[CPOL_BIT]};
      baud_q   <= BAUD_RST;
    end else if (clk_en_i && reg_we_i) begin
      case (reg_addr_i)
        REG_CONTROL_B: ctrl_b_q <= reg_wdata_i;
        REG_CONTROL_C: begin
          cfg_q <= '{mode:  reg_wdata_i[MODE_HI_BIT:MODE_LO_BIT],
                     order: reg_wdata_i[ORDER_BIT],
                     cpha:  reg_wdata_i[CPHA_BIT],
                     cpol:  reg_wdata_i[CPOL_BIT]};
        end
        REG_BAUD_LO: baud_q[7:0] <= reg_wdata_i;
        REG_BAUD_HI: baud_q[BAUD_W-1:8] <= reg_wdata_i[BAUD_HI_W-1:0];
        default: ;
      endcase
    end
  end

  // [R6] one-word transmit buffer beside the shifter
  // [R8] a write to a full buffer is dropped with no collision flag
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_buf_q  <= 8'h00;
      tx_full_q <= 1'b0;
    end else if (clk_en_i) begin
      if (load) begin
        tx_full_q <= 1'b0;
      end else if (wr_data && !tx_full_q && tx_own_q && mspi) begin
        tx_buf_q  <= reg_wdata_i;
        tx_full_q <= 1'b1;
      end
    end
  end

  // [R18] enable takes effect at once, disable waits for idle
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_own_q <= 1'b0;
    end else if (clk_en_i) begin
      if (ctrl_b_q[TXEN_BIT]) begin
        tx_own_q <= 1'b1;
      end else if (!tx_full_q && (st_q == ST_IDLE)) begin
        tx_own_q <= 1'b0;
      end
    end
  end

  // shift engine; baud changes mid-frame take hold at the next compare
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q    <= ST_IDLE;
      tx_sr_q <= 8'h00;
      rx_sr_q <= 8'h00;
      edge_q  <= 4'h0;
      div_q   <= BAUD_RST;
    end else if (clk_en_i) begin
      rx_sr_q <= rx_sr_d;
      case (st_q)
        ST_IDLE: begin
          edge_q <= 4'h0;
          div_q  <= BAUD_RST;
          if (load) begin
            st_q <= ST_SHIFT;
            // phase zero puts the first bit out at load, so skip it here
            if (!cfg_q.cpha) begin
              tx_sr_q <= cfg_q.order ? {1'b0, tx_buf_q[7:1]}
                                     : {tx_buf_q[6:0], 1'b0};
            end else begin
              tx_sr_q <= tx_buf_q;
            end
          end
        end
        ST_SHIFT: begin
          if (!mspi) begin
            // leaving the mode aborts the frame
            st_q <= ST_IDLE;
          end else if (tick) begin
            div_q  <= BAUD_RST;
            edge_q <= edge_q + 4'h1;
            if (frame_done) begin
              st_q <= ST_IDLE;
            end
          end else begin
            div_q <= div_q + {{(BAUD_W-1){1'b0}}, 1'b1};
          end
          if (setup_ev) begin
            tx_sr_q <= cfg_q.order ? {1'b0, tx_sr_q[7:1]}
                                   : {tx_sr_q[6:0], 1'b0};
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // [R10] clock driven here in mode 11 with the transmitter on, idle level from polarity
  // [R20] data on the out pin, clock on the clock pin
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      transfer_clock_pin_o <= CONTROL_C_RST[CPOL_BIT];
      transfer_clock_oe_o  <= 1'b0;
      serial_out_pin_o     <= 1'b1;
      serial_out_oe_o      <= 1'b0;
      serial_in_own_o      <= 1'b0;
    end else if (clk_en_i) begin
      transfer_clock_oe_o <= mspi && tx_own_q;
      serial_out_oe_o     <= tx_own_q;
      // [R16] receiver takes the data-in pin while enabled
      serial_in_own_o     <= ctrl_b_q[RXEN_BIT];
      if (st_q == ST_IDLE) begin
        // [R5] idle level
        transfer_clock_pin_o <= cfg_q.cpol;
      end else if (tick) begin
        transfer_clock_pin_o <= !transfer_clock_pin_o;
      end
      if (setup_ev) begin
        serial_out_pin_o <= load ? (cfg_q.order ? tx_buf_q[0] : tx_buf_q[7])
                                 : cur_bit;
      end
    end
  end

  // two-entry receive buffer: head at index zero
  assign pop     = clk_en_i && rd_data && rxc;
  assign push    = frame_done && ctrl_b_q[RXEN_BIT];
  assign rx_base = rx_cnt_q - {1'b0, pop};

  // [R7] shifter plus two held words
  // [R23] a full buffer ignores the newest word
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_cnt_q <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        rx_mem_q[i] <= 8'h00;
      end
    end else if (clk_en_i) begin
      if (!ctrl_b_q[RXEN_BIT]) begin
        // [R12] disabled receiver flushes the buffer
        rx_cnt_q <= 2'h0;
      end else begin
        for (int i = 0; i < 2; i++) begin
          if (pop && i == 0) begin
            rx_mem_q[0] <= rx_mem_q[1];
          end
          if (push && rx_base < RX_DEPTH && rx_base == 2'(i)) begin
            rx_mem_q[i] <= rx_sr_d;
          end
        end
        if (push && rx_base < RX_DEPTH) begin
          rx_cnt_q <= rx_base + 2'h1;
        end else begin
          rx_cnt_q <= rx_base;
        end
      end
    end
  end

  // [R13] set when all is sent; set beats a same-cycle clear
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      txc_q <= 1'b0;
    end else if (clk_en_i) begin
      if (frame_done && !tx_full_q) begin
        txc_q <= 1'b1;
      end else if (txc_irq_ack_i || (reg_we_i &&
               reg_addr_i == REG_STATUS_A && reg_wdata_i[TXC_BIT])) begin
        txc_q <= 1'b0;
      end
    end
  end

  // read mux, data valid the cycle after the strobe
  // [R24] error bits and reserved bits read zero
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      reg_rdata_o <= 8'h00;
      if (reg_re_i) begin
        case (reg_addr_i)
          REG_STATUS_A:  reg_rdata_o <= {rxc, txc_q, udre, 5'h00};
          REG_CONTROL_B: reg_rdata_o <= {ctrl_b_q[7:3], 3'h0};
          REG_CONTROL_C: reg_rdata_o <= {cfg_q.mode, 3'h0, cfg_q.order,
                                         cfg_q.cpha, cfg_q.cpol};
          REG_DATA:      reg_rdata_o <= rx_mem_q[0];
          REG_BAUD_LO:   reg_rdata_o <= baud_q[7:0];
          REG_BAUD_HI:   reg_rdata_o <= {4'h0, baud_q[BAUD_W-1:8]};
          default:       reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // [R15] each request needs enable, global flag and source flag
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rxc_irq_o  <= 1'b0;
      txc_irq_o  <= 1'b0;
      udre_irq_o <= 1'b0;
    end else if (clk_en_i) begin
      rxc_irq_o  <= ctrl_b_q[RXCIE_BIT] && global_irq_en_i && rxc;
      txc_irq_o  <= ctrl_b_q[TXCIE_BIT] && global_irq_en_i && txc_q;
      udre_irq_o <= ctrl_b_q[TX_BUFFER_EMPTY_IRQ_ENABLE_BIT] && global_irq_en_i && udre;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_edge;
    clk_en_i && st_q == ST_SHIFT && tick;
  endsequence

  sequence s_overflow;
    clk_en_i && push && rx_cnt_q == RX_DEPTH && !pop;
  endsequence

  a_mode_idle: assert property ( // [R1]
    clk_en_i && !mspi |=> st_q == ST_IDLE)
    else $error("shifter ran outside master spi mode");

  a_first_bit: assert property ( // [R3]
    clk_en_i && load && !cfg_q.cpha |=>
    serial_out_pin_o == $past(cfg_q.order ? tx_buf_q[0] : tx_buf_q[7]))
    else $error("first bit not taken from the ordered end");

  a_clock_idle: assert property ( // [R5]
    clk_en_i && st_q == ST_IDLE |=> transfer_clock_pin_o == $past(cfg_q.cpol))
    else $error("idle clock level differs from polarity");

  a_rx_flush: assert property ( // [R12]
    clk_en_i && !ctrl_b_q[RXEN_BIT] |=> !rxc ##0 rx_cnt_q == 2'h0)
    else $error("receive buffer kept data after disable");

  a_txc_set: assert property ( // [R13]
    clk_en_i && frame_done && !tx_full_q |=> txc_q)
    else $error("transmit complete not set at frame end");

  a_irq_gate: assert property ( // [R15]
    clk_en_i |=> rxc_irq_o ==
      $past(ctrl_b_q[RXCIE_BIT] && global_irq_en_i && rxc))
    else $error("receive interrupt not gated by enables");

  a_rx_only_idle: assert property ( // [R17]
    clk_en_i && st_q == ST_IDLE && !tx_own_q |=> st_q == ST_IDLE)
    else $error("frame started without the transmitter");

  a_tx_hold_pin: assert property ( // [R18]
    clk_en_i && tx_own_q && (tx_full_q || st_q == ST_SHIFT) |=> tx_own_q)
    else $error("transmitter released with data pending");

  a_clock_toggle: assert property ( // [R25]
    s_edge |=> transfer_clock_pin_o != $past(transfer_clock_pin_o))
    else $error("clock did not toggle at half period");

  a_overflow_keep: assert property ( // [R23]
    s_overflow |=> rx_cnt_q == RX_DEPTH && $stable(rx_mem_q[1]))
    else $error("overflow overwrote buffered words");

endmodule

//--- pkg/usspi_pkg.sv
// Purpose: shared constants and types of the master-only SPI serial port
// Assumes: 8-bit register port, word indices as register offsets
// Notes:   register indices and the baud split are local choices
package usspi_pkg;

  // register indices on the plain register port
  localparam logic [2:0] REG_STATUS_A  = 3'h0;
  localparam logic [2:0] REG_CONTROL_B = 3'h1;
  localparam logic [2:0] REG_CONTROL_C = 3'h2;
  localparam logic [2:0] REG_DATA      = 3'h3;
  localparam logic [2:0] REG_BAUD_LO   = 3'h4;
  localparam logic [2:0] REG_BAUD_HI   = 3'h5;

  // serial_status_a fields
  localparam int RXC_BIT  = 7;
  localparam int TXC_BIT  = 6;
  localparam int UDRE_BIT = 5;

  // serial_control_b fields
  localparam int RXCIE_BIT = 7;
  localparam int TXCIE_BIT = 6;
  localparam int TX_BUFFER_EMPTY_IRQ_ENABLE_BIT = 5;
  localparam int RXEN_BIT  = 4;
  localparam int TXEN_BIT  = 3;

  // serial_control_c fields
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int ORDER_BIT   = 2;
  localparam int CPHA_BIT    = 1;
  localparam int CPOL_BIT    = 0;

  // mode select encodings
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SYNC  = 2'h1;
  localparam logic [1:0] MODE_RSVD  = 2'h2;
  localparam logic [1:0] MODE_MSPI  = 2'h3;

  // reset values
  localparam logic [7:0]  CONTROL_B_RST = 8'h00;
  localparam logic [7:0]  CONTROL_C_RST = 8'h06;
  localparam logic [11:0] BAUD_RST      = 12'h000;

  // frame shape: 8 bits, two clock edges per bit
  localparam int          FRAME_BITS = 8;
  localparam logic [3:0]  LAST_EDGE  = 4'hF;
  localparam logic [1:0]  RX_DEPTH   = 2'h2;
  localparam int          BAUD_W     = 12;
  localparam int          BAUD_HI_W  = 4;

  // decoded serial_control_c, travels as one word
  typedef struct packed {
    logic [1:0] mode;
    logic       order;
    logic       cpha;
    logic       cpol;
  } usspi_cfg_t;

  typedef enum logic {ST_IDLE, ST_SHIFT} usspi_state_t;

endpackage

//--- design/usspi_insync.sv
// Purpose: bring the serial input pin into the system clock domain
// Assumes: pin is asynchronous to sys_clk_i
// Notes:   output moves only when stages two and three agree
`timescale 1ns/100ps
module usspi_insync
  import usspi_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  input  wire logic clk_en_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // three stages; the first one feeds only the second
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (clk_en_i) begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a change only once it has held for two samples
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      level_o <= 1'b0;
    end else if (clk_en_i && (s2_q == s3_q)) begin
      level_o <= s3_q;
    end
  end

endmodule

//--- verif/usspi_slave_model.sv
// Purpose: behavioural SPI slave on the far side of the master port
// Assumes: select tied active, so the slave always owns its data line
// Notes:   sends base plus frame count, so every frame differs
`timescale 1ns/100ps
module usspi_slave_model (
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       order_i,
  input  wire logic       slow_i,
  input  wire logic       clr_i,
  input  wire logic [7:0] base_i,
  output logic            miso_o,
  output logic [7:0]      rx_o,
  output int              frames_o
);
  int         n;
  logic [7:0] sh;

  // bit i of the current word in the chosen order
  function automatic logic pick(input int i);
    logic [7:0] w;
    w = base_i + 8'(frames_o);
    return order_i ? w[i] : w[7-i];
  endfunction

  initial begin
    n = 0;
    frames_o = 0;
    rx_o = 8'h00;
    sh = 8'h00;
    miso_o = 1'b1;
  end

  // phase zero needs the first bit before the leading edge
  always @(negedge clr_i) begin
    if (!cpha_i)
      miso_o = pick(0);
  end

  // leading edge leaves idle; clr_i hides idle-level moves on reconfig
  // setup and sample
  always @(sclk_i) begin
    if (clr_i)
      n = 0;
    else if ((sclk_i != cpol_i) == cpha_i) begin
      if (slow_i)
        #16;
      miso_o = pick(n);
    end else begin
      sh[order_i ? n : 7-n] = mosi_i;
      n++;
      if (n == 8) begin
        n = 0;
        rx_o = sh;
        frames_o++;
      end
    end
  end
endmodule

//--- verif/test_usart_master_spi_mode.sv
// Purpose: self-checking bench for the master SPI serial port
// Assumes: clock enable tied high; slave model on the link pins
// Notes:   baud 7 gives a 128 ns link clock, nearest to 125 ns
`timescale 1ns/100ps
module test_usart_master_spi_mode;
  import usspi_pkg::*;
  localparam int         HALF = 8;
  localparam logic [7:0] BAUD = 8'(HALF - 1);
  logic       sys_clk_i, arst_n_i, we, re, gie, ack, clr, slow;
  logic       irq_rx, irq_tx, irq_ud, miso, own, mosi, mosi_oe;
  logic       sclk, sclk_oe, sclk_p, cpol, cpha, order;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, base, srx, d;
  int         frames, err_total, check_count, cyc, tog, t_first, t_last;
  int         f;

  usspi_top dut_u (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we),
    .reg_re_i(re), .reg_rdata_o(rdata), .global_irq_en_i(gie),
    .txc_irq_ack_i(ack), .rxc_irq_o(irq_rx), .txc_irq_o(irq_tx),
    .udre_irq_o(irq_ud), .serial_in_pin_i(miso), .serial_in_own_o(own),
    .serial_out_pin_o(mosi), .serial_out_oe_o(mosi_oe),
    .transfer_clock_pin_o(sclk), .transfer_clock_oe_o(sclk_oe));

  usspi_slave_model slave_u (
    .sclk_i(sclk), .mosi_i(mosi), .cpol_i(cpol), .cpha_i(cpha),
    .order_i(order), .slow_i(slow), .clr_i(clr), .base_i(base),
    .miso_o(miso), .rx_o(srx), .frames_o(frames));

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // link clock edges in system cycles, plus the hang guard
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    sclk_p <= sclk;
    if (sclk !== sclk_p) begin
      tog <= tog + 1;
      t_last <= cyc;
      if (tog == 0)
        t_first <= cyc;
    end
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask

  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge sys_clk_i);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge sys_clk_i);
    re <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] e,
                     input string nm);
    logic [7:0] v;
    rd(a, v);
    chk8(nm, e, v);
  endtask

  // bounded poll of one status flag
  task automatic wait_st(input int b);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 400 && s[b] !== 1'b1; i++)
      rd(REG_STATUS_A, s);
    chk8("status_wait", 8'h01, {7'h00, s[b]});
  endtask

  // model held quiet while the clock idle level may move
  task automatic cfg(input logic [1:0] m, input logic o, input logic ph,
                     input logic po);
    clr = 1'b1;
    order = o;
    cpha = ph;
    cpol = po;
    wr(REG_CONTROL_C, {m, 3'h0, o, ph, po});
    tick(4);
    clr = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] v);
    int f0;
    f0 = frames;
    tog = 0;
    wr(REG_DATA, v);
    wait_st(RXC_BIT);
    chk8("slave_rx", v, srx);
    rdc(REG_DATA, base + 8'(f0), "dut_rx");
    chk8("toggles", 8'h10, 8'(tog));
    chk8("span", 8'(15 * HALF), 8'(t_last - t_first));
  endtask

  initial begin
    arst_n_i = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    we = 1'b0;
    re = 1'b0;
    gie = 1'b0;
    ack = 1'b0;
    slow = 1'b0;
    clr = 1'b1;
    cpol = 1'b0;
    cpha = 1'b0;
    order = 1'b0;
    base = 8'h1D;
    err_total = 0;
    check_count = 0;
    cyc = 0;
    tog = 0;
    tick(4);
    chk8("out_idle", 8'h01, {7'h00, mosi});
    chk8("out_oe", 8'h00, {7'h00, mosi_oe});
    arst_n_i <= 1'b1;
    rdc(REG_STATUS_A, 8'h20, "status");
    rdc(REG_CONTROL_C, CONTROL_C_RST, "ctrl_c");
    wr(3'h6, 8'hFF);
    rdc(3'h6, 8'h00, "unmapped");
    wr(REG_BAUD_LO, BAUD);
    wr(REG_CONTROL_B, 8'h18);
    tick(2);
    chk8("in_own", 8'h01, {7'h00, own});
    // every clock mode in both orders, slow answers on some
    for (int i = 0; i < 8; i++) begin
      slow = i[0] ^ i[1];
      cfg(MODE_MSPI, i[2], i[1], i[0]);
      rdc(REG_CONTROL_C, {MODE_MSPI, 3'h0, 3'(i)}, "ctrl_c");
      chk8("clk_idle", {7'h00, cpol}, {7'h00, sclk});
      chk8("clk_oe", 8'h01, {7'h00, sclk_oe});
      xfer(8'h96 ^ 8'(i));
      rdc(REG_STATUS_A, 8'h60, "st_done");
      wr(REG_STATUS_A, 8'h40);
      rdc(REG_STATUS_A, 8'h20, "st_clr");
    end
    // second word waits, third word overflows the receiver
    f = frames;
    wr(REG_DATA, 8'h11);
    wr(REG_DATA, 8'h22);
    rdc(REG_STATUS_A, 8'h00, "st_full");
    wait_st(UDRE_BIT);
    wr(REG_DATA, 8'h33);
    wait_st(TXC_BIT);
    chk8("frames", 8'(f + 3), 8'(frames));
    chk8("slave_last", 8'h33, srx);
    rdc(REG_DATA, base + 8'(f), "rx_first");
    rdc(REG_DATA, base + 8'(f + 1), "rx_second");
    rdc(REG_STATUS_A, 8'h60, "st_ovf");
    // receiver disable flushes an unread word
    wr(REG_DATA, 8'h44);
    wait_st(RXC_BIT);
    wr(REG_CONTROL_B, 8'h08);
    rdc(REG_STATUS_A, 8'h60, "st_flush");
    chk8("in_free", 8'h00, {7'h00, own});
    // receiver alone starts nothing
    wr(REG_CONTROL_B, 8'h10);
    f = frames;
    wr(REG_DATA, 8'h55);
    tick(200);
    chk8("rx_only", 8'(f), 8'(frames));
    chk8("clk_oe_off", 8'h00, {7'h00, sclk_oe});
    // transmitter disable waits for the frame in flight
    wr(REG_CONTROL_B, 8'h18);
    wr(REG_DATA, 8'h66);
    wr(REG_CONTROL_B, 8'h10);
    tick(1);
    chk8("oe_busy", 8'h01, {7'h00, mosi_oe});
    wait_st(RXC_BIT);
    tick(4);
    chk8("oe_free", 8'h00, {7'h00, mosi_oe});
    chk8("tx_late", 8'h66, srx);
    rd(REG_DATA, d);
    // the other mode codes leave the shifter idle
    for (int m = 0; m < 3; m++) begin
      cfg(2'(m), 1'b0, 1'b0, 1'b0);
      wr(REG_CONTROL_B, 8'h18);
      f = frames;
      wr(REG_DATA, 8'h77);
      tick(200);
      chk8("mode_idle", 8'(f), 8'(frames));
    end
    // interrupt enables against the global flag
    cfg(MODE_MSPI, 1'b0, 1'b0, 1'b0);
    wr(REG_STATUS_A, 8'h40);
    wr(REG_CONTROL_B, 8'hF8);
    tick(3);
    chk8("irq_off", 8'h00, {5'h00, irq_rx, irq_tx, irq_ud});
    @(posedge sys_clk_i);
    gie <= 1'b1;
    tick(3);
    chk8("irq_ud", 8'h01, {5'h00, irq_rx, irq_tx, irq_ud});
    wr(REG_DATA, 8'h88);
    wait_st(RXC_BIT);
    tick(2);
    chk8("irq_all", 8'h07, {5'h00, irq_rx, irq_tx, irq_ud});
    @(posedge sys_clk_i);
    ack <= 1'b1;
    @(posedge sys_clk_i);
    ack <= 1'b0;
    tick(3);
    chk8("irq_ack", 8'h05, {5'h00, irq_rx, irq_tx, irq_ud});
    rd(REG_DATA, d);
    wr(REG_CONTROL_B, 8'h18);
    tick(3);
    chk8("irq_mask", 8'h00, {5'h00, irq_rx, irq_tx, irq_ud});
    test_done();
  end
endmodule
